// File: rtl/cbbd_defines.svh
`ifndef CBBD_DEFINES_SVH
`define CBBD_DEFINES_SVH
// ==========================================================================
// Register offsets and fields
`define CBBD_REG_CTRL     8'h00
`define CBBD_REG_PC       8'h04
`define CBBD_REG_CORE     8'h08
`define CBBD_REG_STAT     8'h0C
`define CBBD_CTRL_RUN     0
`define CBBD_CORE_X_LSB   8
`define CBBD_CORE_CCR_LSB 16
`define CBBD_STAT_STOP    0
`define CBBD_STAT_WAIT    1
`define CBBD_STAT_ILL     2
`define CBBD_STAT_TAKEN   3
`define CBBD_STAT_CYC_LSB 4
`define CBBD_STAT_ST_LSB  8
// ==========================================================================
// Reset values and the direct-page upper address byte
`define CBBD_PC_RST       16'h0100
`define CBBD_CCR_RST      5'h08
`define CBBD_DIR_PAGE     8'h00
// ==========================================================================
// Documented cycle counts
`define CBBD_CYC_LIT      4'h2
`define CBBD_CYC_DIR      4'h3
`define CBBD_CYC_FULL     4'h4
`define CBBD_CYC_IXW      4'h5
`define CBBD_CYC_IXB      4'h4
`define CBBD_CYC_IXN      4'h3
`define CBBD_CYC_RMW_DIR  4'h5
`define CBBD_CYC_RMW_INH  4'h3
`define CBBD_CYC_RMW_IXB  4'h6
`define CBBD_CYC_RMW_IXN  4'h5
`define CBBD_CYC_BIT      4'h5
`define CBBD_CYC_REL      4'h3
`define CBBD_CYC_CTRL     4'h2
`endif

// File: rtl/cbbd_pkg.sv
package cbbd_pkg;
  typedef enum logic [3:0] {
    K_ILLEGAL = 4'b0000, K_ADD_CARRY = 4'b0001, K_ADD_PLAIN = 4'b0010, K_AND_MEM = 4'b0011,
    K_SHIFT_LEFT_ARITH = 4'b0100, K_SHIFT_RIGHT_ARITH = 4'b0101, K_COND_BRANCH = 4'b0110,
    K_BRANCH_BIT = 4'b0111, K_MEMORY_BIT = 4'b1000, K_STOP = 4'b1001, K_WAIT = 4'b1010
  } cbbd_kind_t;
  typedef enum logic [3:0] {
    M_LITERAL_OPERAND = 4'b0000, M_DIRECT = 4'b0001, M_FULL_ADDRESS = 4'b0010,
    M_INDEXED_WORD = 4'b0011, M_INDEXED_BYTE = 4'b0100, M_INDEXED_NONE = 4'b0101,
    M_IMPLIED_A = 4'b0110, M_IMPLIED_X = 4'b0111, M_RELATIVE = 4'b1000
  } cbbd_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_FETCH = 4'b0001, ST_OPR1 = 4'b0010, ST_OPR2 = 4'b0011, ST_READ = 4'b0100,
    ST_EXEC = 4'b0101, ST_WRITE = 4'b0110, ST_STOP = 4'b0111, ST_WAIT = 4'b1000
  } cbbd_state_t;
  typedef struct packed {
    cbbd_kind_t kind;
    cbbd_mode_t mode;
    logic [2:0] bit_sel;
    logic       bit_pol;
    logic [3:0] cycles;
  } cbbd_dec_t;
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cbbd_ccr_t;
  typedef struct packed {
    logic [7:0] res;
    cbbd_ccr_t  f;
  } cbbd_alu_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbbd_mem_t;
endpackage

// File: rtl/cbbd_core.sv
// The address map and the APB interface to the registers were chosen for this implementation.
`include "cbbd_defines.svh"
// Overview of operation
// - False branch test leaves the program counter at the next instruction.
// - Bit-test branches are three bytes: opcode, page-zero address, displacement.
// - Bit number and set/clear polarity come from the opcode byte.
// - Taken bit-test branch goes to next address plus signed displacement.
// - Bit-test branches always copy the tested bit into carry.
// - Any single bit of the lowest 256 bytes can be set or cleared.
// - Add with carry: opcodes A9..F9, six modes, updates H N Z C.
// - Plain add: opcodes AB..FB, six modes, updates H N Z C.
// - Logical AND: opcodes A4..F4, six modes, updates only N and Z.
// - Left shift: opcodes 38..78, five forms, documented cycle counts.
// - Right shift: opcodes 37..77, five forms, updates N Z C.
// - Opcode 24 branches when carry clear, flags untouched.
// - Opcode 25 branches when carry set, flags untouched.
// - Opcode 27 branches when zero flag set.
// - Opcodes 28 and 29 branch on half-carry clear or set.
// - Stop halts the oscillator and unmasks the interrupt pin for wake-up.
// - Wait halts the CPU clock with interrupts unmasked.
// - Direct operands use zero as the upper address byte.
// - Single-bit set and clear exist only in direct form.
module cbbd_core #(
  parameter logic [15:0] RESET_PC = `CBBD_PC_RST,
  parameter int          APB_AW   = 8
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [APB_AW-1:0]   PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  output cbbd_pkg::cbbd_mem_t      MEM_OUT,
  input  wire logic [7:0]          MEM_RDATA,
  input  wire logic                MEM_ACK,
  input  wire logic                IRQ_N,
  output logic                     OSC_RUN,
  output logic                     CPU_CLK_RUN
);
  import cbbd_pkg::*;

  if (APB_AW < 8 || APB_AW > 32) begin : g_bad_aw
    $error("APB_AW must lie between 8 and 32");
  end

  // ========================================================================
  // Helpers
  function automatic cbbd_dec_t decode(input logic [7:0] op);
    cbbd_dec_t d;
    d = '{kind: K_ILLEGAL, mode: M_DIRECT, bit_sel: op[3:1], bit_pol: ~op[0], cycles: `CBBD_CYC_CTRL};
    case (op[7:4])
      4'hA: begin d.mode = M_LITERAL_OPERAND; d.cycles = `CBBD_CYC_LIT; end
      4'hB: begin d.mode = M_DIRECT; d.cycles = `CBBD_CYC_DIR; end
      4'hC: begin d.mode = M_FULL_ADDRESS; d.cycles = `CBBD_CYC_FULL; end
      4'hD: begin d.mode = M_INDEXED_WORD; d.cycles = `CBBD_CYC_IXW; end
      4'hE: begin d.mode = M_INDEXED_BYTE; d.cycles = `CBBD_CYC_IXB; end
      4'hF: begin d.mode = M_INDEXED_NONE; d.cycles = `CBBD_CYC_IXN; end
      4'h3: begin d.mode = M_DIRECT; d.cycles = `CBBD_CYC_RMW_DIR; end
      4'h4: begin d.mode = M_IMPLIED_A; d.cycles = `CBBD_CYC_RMW_INH; end
      4'h5: begin d.mode = M_IMPLIED_X; d.cycles = `CBBD_CYC_RMW_INH; end
      4'h6: begin d.mode = M_INDEXED_BYTE; d.cycles = `CBBD_CYC_RMW_IXB; end
      4'h7: begin d.mode = M_INDEXED_NONE; d.cycles = `CBBD_CYC_RMW_IXN; end
      4'h2: begin d.mode = M_RELATIVE; d.cycles = `CBBD_CYC_REL; end
      default: begin d.mode = M_DIRECT; d.cycles = `CBBD_CYC_BIT; end
    endcase
    if (op[7:4] >= 4'hA) begin
      case (op[3:0])
        4'h9: d.kind = K_ADD_CARRY;
        4'hB: d.kind = K_ADD_PLAIN;
        4'h4: d.kind = K_AND_MEM;
        default: d.kind = K_ILLEGAL;
      endcase
    end else if (op[7:4] >= 4'h3 && op[7:4] <= 4'h7) begin
      if (op[3:0] == 4'h8) d.kind = K_SHIFT_LEFT_ARITH;
      else if (op[3:0] == 4'h7) d.kind = K_SHIFT_RIGHT_ARITH;
    end else if (op[7:4] == 4'h0) begin
      d.kind = K_BRANCH_BIT;
    end else if (op[7:4] == 4'h1) begin
      d.kind = K_MEMORY_BIT;
    end else if (op[7:4] == 4'h2) begin
      if (op[3:0] inside {4'h4, 4'h5, 4'h7, 4'h8, 4'h9}) d.kind = K_COND_BRANCH;
    end else if (op == 8'h8E) begin
      d.kind = K_STOP;
      d.mode = M_IMPLIED_A;
    end else if (op == 8'h8F) begin
      d.kind = K_WAIT;
      d.mode = M_IMPLIED_A;
    end
    return d;
  endfunction

  function automatic logic cond_true(input logic [3:0] lo, input cbbd_ccr_t f);
    case (lo)
      4'h4: return ~f.c;
      4'h5: return f.c;
      4'h7: return f.z;
      4'h8: return ~f.h;
      4'h9: return f.h;
      default: return 1'b0;
    endcase
  endfunction

  function automatic cbbd_alu_t alu(input cbbd_kind_t k, input logic [7:0] a, input logic [7:0] m,
                                    input cbbd_ccr_t f_in);
    cbbd_alu_t o;
    logic [8:0] s;
    o.f = f_in;
    o.res = a;
    s = {1'b0, a} + {1'b0, m} + {8'h00, (k == K_ADD_CARRY) & f_in.c};
    case (k)
      K_ADD_CARRY, K_ADD_PLAIN: begin
        o.res = s[7:0];
        o.f.c = s[8];
        o.f.h = (a[3] & m[3]) | (m[3] & ~s[3]) | (~s[3] & a[3]);
      end
      K_AND_MEM:           o.res = a & m;
      K_SHIFT_LEFT_ARITH:  begin o.res = {m[6:0], 1'b0}; o.f.c = m[7]; end
      K_SHIFT_RIGHT_ARITH: begin o.res = {m[7], m[7:1]}; o.f.c = m[0]; end
      default: ;
    endcase
    o.f.n = o.res[7];
    o.f.z = (o.res == 8'h00);
    return o;
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] r);
    return {{8{r[7]}}, r};
  endfunction

  // ========================================================================
  // State
  cbbd_state_t state_q;
  cbbd_dec_t   dec_q, dec_now;
  cbbd_ccr_t   ccr_q;
  cbbd_mem_t   mem_q;
  cbbd_alu_t   alu_o;
  logic [7:0]  op_q, b1_q, m_q, a_q, x_q, alu_src, bit_val;
  logic [15:0] pc_q, ea_q, pc_start_q, bus_addr;
  logic [3:0]  cyc_q;
  logic        run_q, ill_q, taken_q, irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
  logic        take, bus_state, issue, bit_m, ill_set, apb_wr, apb_hi_ok;
  logic [7:0]  apb_off;

  assign dec_now   = decode(MEM_RDATA);
  assign take      = mem_q.req & MEM_ACK;
  assign bus_state = state_q inside {ST_FETCH, ST_OPR1, ST_OPR2, ST_READ, ST_WRITE};
  assign issue     = bus_state & ~mem_q.req & ~(state_q == ST_FETCH & ~run_q);
  assign bus_addr  = (state_q inside {ST_READ, ST_WRITE}) ? ea_q : pc_q;
  assign alu_src   = (dec_q.mode == M_IMPLIED_A) ? a_q : (dec_q.mode == M_IMPLIED_X) ? x_q : m_q;
  assign alu_o     = alu(dec_q.kind, a_q, alu_src, ccr_q);
  assign bit_m     = m_q[dec_q.bit_sel];
  assign bit_val   = dec_q.bit_pol ? (m_q | (8'h01 << dec_q.bit_sel))
                                   : (m_q & ~(8'h01 << dec_q.bit_sel));
  assign ill_set   = state_q == ST_FETCH & take & dec_now.kind == K_ILLEGAL;
  assign apb_off   = PADDR[7:0];
  assign apb_hi_ok = (PADDR >> 8) == '0;
  assign apb_wr    = PSEL & PENABLE & PWRITE & apb_hi_ok;
  assign MEM_OUT   = mem_q;
  assign PREADY    = 1'b1;
  assign OSC_RUN     = state_q != ST_STOP;
  assign CPU_CLK_RUN = ~(state_q inside {ST_STOP, ST_WAIT});

  // ========================================================================
  // Interrupt pin synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_s1_q  <= 1'b1;
      irq_s2_q  <= 1'b1;
      irq_s3_q  <= 1'b1;
      irq_lvl_q <= 1'b1;
    end else begin
      irq_s1_q <= IRQ_N;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (irq_s2_q == irq_s3_q) irq_lvl_q <= irq_s3_q;
    end
  end

  // ========================================================================
  // Control and sticky status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) run_q <= 1'b0;
    else if (apb_wr && apb_off == `CBBD_REG_CTRL) run_q <= PWDATA[`CBBD_CTRL_RUN];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ill_q <= 1'b0;
    else if (ill_set) ill_q <= 1'b1;
    else if (apb_wr && apb_off == `CBBD_REG_STAT && PWDATA[`CBBD_STAT_ILL]) ill_q <= 1'b0;
  end

  // ========================================================================
  // APB read data, sampled in the setup phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (!apb_hi_ok) PSLVERR <= 1'b1;
      else case (apb_off)
        `CBBD_REG_CTRL: PRDATA[`CBBD_CTRL_RUN] <= run_q;
        `CBBD_REG_PC:   PRDATA[15:0] <= pc_q;
        `CBBD_REG_CORE: PRDATA[20:0] <= {ccr_q, x_q, a_q};
        `CBBD_REG_STAT: PRDATA[11:0] <= {state_q, cyc_q, taken_q, ill_q, state_q == ST_WAIT, state_q == ST_STOP};
        default:        PSLVERR <= 1'b1;
      endcase
    end
  end

  // ========================================================================
  // Sequencer and memory bus
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      mem_q   <= '0;
      dec_q   <= '0;
      ccr_q   <= `CBBD_CCR_RST;
      pc_q    <= RESET_PC;
      pc_start_q <= RESET_PC;
      ea_q    <= 16'h0000;
      op_q    <= 8'h00;
      b1_q    <= 8'h00;
      m_q     <= 8'h00;
      a_q     <= 8'h00;
      x_q     <= 8'h00;
      cyc_q   <= 4'h0;
      taken_q <= 1'b0;
    end else if (issue) begin
      mem_q.req  <= 1'b1;
      mem_q.we   <= state_q == ST_WRITE;
      mem_q.addr <= bus_addr;
      if (state_q == ST_FETCH) pc_start_q <= pc_q;
    end else begin
      if (take) mem_q.req <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (apb_wr && apb_off == `CBBD_REG_PC) pc_q <= PWDATA[15:0];
          if (apb_wr && apb_off == `CBBD_REG_CORE) {ccr_q, x_q, a_q} <= PWDATA[20:0];
          if (run_q) state_q <= ST_FETCH;
        end
        ST_FETCH: begin
          if (!run_q && !mem_q.req) state_q <= ST_IDLE;
          else if (take) begin
            op_q  <= MEM_RDATA;
            dec_q <= dec_now;
            cyc_q <= dec_now.cycles;
            pc_q  <= pc_q + 16'h0001;
            if (dec_now.kind == K_ILLEGAL) state_q <= ST_FETCH;
            else if (dec_now.mode inside {M_IMPLIED_A, M_IMPLIED_X}) state_q <= ST_EXEC;
            else if (dec_now.mode == M_INDEXED_NONE) begin
              ea_q    <= {`CBBD_DIR_PAGE, x_q};
              state_q <= ST_READ;
            end else state_q <= ST_OPR1;
          end
        end
        ST_OPR1: if (take) begin
          b1_q <= MEM_RDATA;
          pc_q <= pc_q + 16'h0001;
          unique case (dec_q.mode)
            M_LITERAL_OPERAND: begin m_q <= MEM_RDATA; state_q <= ST_EXEC; end
            M_RELATIVE: state_q <= ST_EXEC;
            M_DIRECT: begin ea_q <= {`CBBD_DIR_PAGE, MEM_RDATA}; state_q <= ST_READ; end
            M_INDEXED_BYTE: begin
              ea_q    <= {7'h00, {1'b0, MEM_RDATA} + {1'b0, x_q}};
              state_q <= ST_READ;
            end
            default: state_q <= ST_OPR2;
          endcase
        end
        ST_OPR2: if (take) begin
          pc_q <= pc_q + 16'h0001;
          if (dec_q.kind == K_BRANCH_BIT) begin
            b1_q    <= MEM_RDATA;
            state_q <= ST_EXEC;
          end else begin
            ea_q    <= {b1_q, MEM_RDATA} + ((dec_q.mode == M_INDEXED_WORD) ? {8'h00, x_q} : 16'h0000);
            state_q <= ST_READ;
          end
        end
        ST_READ: if (take) begin
          m_q     <= MEM_RDATA;
          state_q <= (dec_q.kind == K_BRANCH_BIT) ? ST_OPR2 : ST_EXEC;
        end
        ST_EXEC: begin
          state_q <= ST_FETCH;
          taken_q <= 1'b0;
          case (dec_q.kind)
            K_ADD_CARRY, K_ADD_PLAIN, K_AND_MEM: begin
              a_q   <= alu_o.res;
              ccr_q <= alu_o.f;
            end
            K_SHIFT_LEFT_ARITH, K_SHIFT_RIGHT_ARITH: begin
              ccr_q <= alu_o.f;
              if (dec_q.mode == M_IMPLIED_A) a_q <= alu_o.res;
              else if (dec_q.mode == M_IMPLIED_X) x_q <= alu_o.res;
              else begin
                mem_q.wdata <= alu_o.res;
                state_q     <= ST_WRITE;
              end
            end
            K_MEMORY_BIT: begin
              mem_q.wdata <= bit_val;
              state_q     <= ST_WRITE;
            end
            K_COND_BRANCH: if (cond_true(op_q[3:0], ccr_q)) begin
              taken_q <= 1'b1;
              pc_q    <= pc_q + sext(b1_q);
            end
            K_BRANCH_BIT: begin
              ccr_q.c <= bit_m;
              if (bit_m == dec_q.bit_pol) begin
                taken_q <= 1'b1;
                pc_q    <= pc_q + sext(b1_q);
              end
            end
            K_STOP: begin ccr_q.i <= 1'b0; state_q <= ST_STOP; end
            K_WAIT: begin ccr_q.i <= 1'b0; state_q <= ST_WAIT; end
            default: ;
          endcase
        end
        ST_WRITE: if (take) state_q <= ST_FETCH;
        ST_STOP, ST_WAIT: if (!irq_lvl_q) state_q <= ST_FETCH;
      endcase
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic exec;
  assign exec = state_q == ST_EXEC;

  chk_branch_skip: assert property (exec && dec_q.kind == K_COND_BRANCH && !cond_true(op_q[3:0], ccr_q)
    |=> pc_q == $past(pc_q) && state_q == ST_FETCH) else $error("false branch moved pc");
  chk_bit_branch_len: assert property (exec && dec_q.kind == K_BRANCH_BIT
    |-> pc_q == pc_start_q + 16'h0003) else $error("bit branch length wrong");
  chk_bit_decode: assert property (state_q == ST_FETCH && take && MEM_RDATA[7:4] == 4'h0
    |=> dec_q.kind == K_BRANCH_BIT && dec_q.bit_sel == $past(MEM_RDATA[3:1])
        && dec_q.bit_pol == !$past(MEM_RDATA[0])
        && dec_q.cycles == 4'h5) else $error("bit branch decode wrong");
  chk_bit_target: assert property (exec && dec_q.kind == K_BRANCH_BIT && bit_m == dec_q.bit_pol
    |=> pc_q == $past(pc_q) + sext($past(b1_q))) else $error("bit branch target wrong");
  chk_bit_carry: assert property (exec && dec_q.kind == K_BRANCH_BIT
    |=> ccr_q.c == $past(bit_m)) else $error("tested bit not in carry");
  chk_bit_write: assert property (state_q == ST_WRITE && mem_q.req && dec_q.kind == K_MEMORY_BIT
    |-> mem_q.wdata[dec_q.bit_sel] == dec_q.bit_pol && ((mem_q.wdata ^ m_q) & ~(8'h01 << dec_q.bit_sel)) == 8'h00)
    else $error("bit write disturbed other bits");
  chk_adc_decode: assert property (state_q == ST_FETCH && take && MEM_RDATA == 8'hD9
    |=> dec_q.kind == K_ADD_CARRY && dec_q.cycles == 4'h5) else $error("add with carry decode wrong");
  chk_add_result: assert property (exec && dec_q.kind == K_ADD_PLAIN
    |=> a_q == 8'($past(a_q) + $past(m_q)) && ccr_q.i == $past(ccr_q.i)) else $error("add result wrong");
  chk_and_flags: assert property (exec && dec_q.kind == K_AND_MEM
    |=> ccr_q.h == $past(ccr_q.h) && ccr_q.c == $past(ccr_q.c)) else $error("and touched h or c");
  chk_shl_decode: assert property (state_q == ST_FETCH && take && MEM_RDATA == 8'h68
    |=> dec_q.kind == K_SHIFT_LEFT_ARITH && dec_q.cycles == 4'h6) else $error("left shift decode wrong");
  chk_shr_flags: assert property (exec && dec_q.kind == K_SHIFT_RIGHT_ARITH
    |=> ccr_q.c == $past(alu_src[0]) && ccr_q.n == $past(alu_src[7])) else $error("right shift flags wrong");
  chk_branch_flags: assert property (exec && dec_q.kind == K_COND_BRANCH
    |=> $stable(ccr_q)) else $error("branch changed flags");
  chk_rel_target: assert property (exec && dec_q.kind == K_COND_BRANCH && cond_true(op_q[3:0], ccr_q)
    |=> pc_q == $past(pc_q) + sext($past(b1_q))) else $error("branch target wrong");
  chk_stop_halt: assert property (exec && dec_q.kind == K_STOP
    |=> !OSC_RUN && !ccr_q.i) else $error("stop did not halt");
  chk_wait_halt: assert property (exec && dec_q.kind == K_WAIT
    |=> OSC_RUN && !CPU_CLK_RUN && !ccr_q.i) else $error("wait did not halt");
  chk_direct_page: assert property (state_q == ST_READ && mem_q.req && dec_q.mode == M_DIRECT
    |-> mem_q.addr[15:8] == 8'h00) else $error("direct high byte not zero");
  chk_bit_set_direct: assert property (state_q == ST_FETCH && take && MEM_RDATA[7:4] == 4'h1
    |=> dec_q.kind == K_MEMORY_BIT && dec_q.mode == M_DIRECT) else $error("bit set mode wrong");

  cov_bit_taken: cover property (exec && dec_q.kind == K_BRANCH_BIT && bit_m == dec_q.bit_pol);
  cov_rel_taken: cover property (exec && dec_q.kind == K_COND_BRANCH && cond_true(op_q[3:0], ccr_q));
  cov_stop_wake: cover property (state_q == ST_STOP ##1 state_q == ST_FETCH);
  cov_bit_write: cover property (state_q == ST_WRITE && take && dec_q.kind == K_MEMORY_BIT);
endmodule

// File: tb/cbbd_mem_model.sv
// ==========================================================================
// Program and data memory, answering promptly and slowly in turn
module cbbd_mem_model
  import cbbd_pkg::*;
(
  input  wire logic                CLK,
  input  wire cbbd_pkg::cbbd_mem_t MEM_OUT,
  output logic [7:0]               MEM_RDATA,
  output logic                     MEM_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] wait_q = 2'h0;
  logic       slow_q = 1'b0;
  initial begin
    MEM_ACK = 1'b0;
    MEM_RDATA = 8'hA5;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Idle data toggles so a stale byte is never mistaken for an answer
  always @(posedge CLK) begin
    MEM_RDATA <= ~MEM_RDATA;
    MEM_ACK <= 1'b0;
    if (MEM_OUT.req && !MEM_ACK) begin
      if (wait_q == (slow_q ? 2'h2 : 2'h0)) begin
        MEM_ACK <= 1'b1;
        MEM_RDATA <= mem[MEM_OUT.addr];
        wait_q <= 2'h0;
        slow_q <= !slow_q;
        if (MEM_OUT.we) mem[MEM_OUT.addr] <= MEM_OUT.wdata;
      end else wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// File: tb/cpu_branch_bit_decode_bench.sv
module cpu_branch_bit_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbbd_pkg::*;
  logic        CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, IRQ_N = 1'b1;
  logic [7:0]  PADDR = 8'h00, MEM_RDATA;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, OSC_RUN, CPU_CLK_RUN, MEM_ACK, err;
  cbbd_mem_t   MEM_OUT;
  int          n_mismatch = 0, checked = 0;
  logic [7:0]  ops [5] = '{8'h24, 8'h25, 8'h27, 8'h28, 8'h29};
  int          idx [5] = '{0, 0, 1, 4, 4};
  logic        pol [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [4:0]  ccr;
  always #12.5 CLK = ~CLK;
  cbbd_core uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MEM_OUT(MEM_OUT), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .IRQ_N(IRQ_N),
    .OSC_RUN(OSC_RUN), .CPU_CLK_RUN(CPU_CLK_RUN));
  cbbd_mem_model mem_i (.CLK(CLK), .MEM_OUT(MEM_OUT), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
  // ==========================================================================
  // Tasks
  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic poke(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) mem_i.mem[a + 16'(i)] = b[i];
  endtask
  // Load A/X/CCR and run from 0x0100
  task automatic start(input logic [31:0] core);
    apb(1'b1, 8'h08, core);
    apb(1'b1, 8'h04, 32'h0000_0100);
    apb(1'b1, 8'h00, 32'h0000_0001);
  endtask
  // Halt at an instruction boundary, then read A/X/CCR
  task automatic halt;
    apb(1'b1, 8'h00, 32'h0000_0000);
    rd = 32'h0000_0F00;
    for (int i = 0; i < 100 && rd[11:8] !== 4'h0; i++) apb(1'b0, 8'h0C, 32'h0);
    compare("idle state", {28'h0, rd[11:8]}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
  endtask
  task automatic run(input logic [31:0] core);
    start(core);
    repeat (300) @(posedge CLK);
    halt;
  endtask
  task automatic check_pc(input logic [15:0] exp);
    apb(1'b0, 8'h04, 32'h0);
    compare("pc", rd, {16'h0, exp});
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (40000) @(posedge CLK);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    compare("osc run", {31'h0, OSC_RUN}, 32'h1);
    compare("cpu clk run", {31'h0, CPU_CLK_RUN}, 32'h1);
    check_pc(16'h0100);
    apb(1'b0, 8'h08, 32'h0);
    compare("core reset", rd, 32'h0008_0000);
    apb(1'b0, 8'h10, 32'h0);
    compare("unmapped err", {31'h0, err}, 32'h1);
    compare("unmapped data", rd, 32'h0);
    // Bit-test branches: fall-through, taken, carry copy, page-zero operand
    poke(16'h0080, '{8'h80});
    poke(16'h0180, '{8'h00});
    poke(16'h0100, '{8'h0F, 8'h80, 8'h03, 8'hA9, 8'h00, 8'h0E, 8'h80, 8'h02, 8'hAB, 8'h10,
                     8'hA9, 8'h00, 8'h01, 8'hF0, 8'hFD});
    run(32'h0);
    compare("bit branch acc", {24'h0, rd[7:0]}, 32'h2);
    check_pc(16'h010C);
    // Shifts, AND, direct add, set-bit on page zero
    poke(16'h0090, '{8'h11});
    poke(16'h00F1, '{8'h01});
    poke(16'h0100, '{8'h47, 8'h48, 8'hA4, 8'hF0, 8'hBB, 8'h90, 8'h10, 8'h85, 8'h00, 8'hF1, 8'hFD});
    run(32'h0000_0081);
    compare("alu acc", {24'h0, rd[7:0]}, 32'h91);
    compare("alu flags", {27'h0, rd[20:16]}, 32'h05);
    compare("bit set", {24'h0, mem_i.mem[16'h0085]}, 32'h01);
    compare("bit set page", {24'h0, mem_i.mem[16'h0185]}, 32'h00);
    check_pc(16'h0108);
    // Flag branches, each with the tested flag clear and set
    poke(16'h0101, '{8'h03, 8'h01, 8'hF0, 8'hFD, 8'h01, 8'hF0, 8'hFD});
    for (int i = 0; i < 5; i++) begin
      for (int v = 0; v < 2; v++) begin
        ccr = (5'h16 & ~(5'h01 << idx[i])) | (5'(v) << idx[i]);
        poke(16'h0100, '{ops[i]});
        run({11'h0, ccr, 16'h0});
        compare("flags kept", {28'h0, rd[20:17]}, {28'h0, ccr[4:1]});
        check_pc((v[0] == pol[i]) ? 16'h0105 : 16'h0102);
      end
    end
    // Indexed add and shift, stop and wait wake-up, illegal opcode flag
    poke(16'h0100, '{8'hD9, 8'h00, 8'h80, 8'h68, 8'h70, 8'h8E, 8'h01, 8'hF2, 8'h00, 8'h8F, 8'h9D,
                     8'h00, 8'hF1, 8'hFD});
    start(32'h0001_1001);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 200 && CPU_CLK_RUN !== 1'b0; i++) @(negedge CLK);
      compare("halt osc run", {31'h0, OSC_RUN}, {31'h0, k[0]});
      compare("halt cpu clk", {31'h0, CPU_CLK_RUN}, 32'h0);
      @(posedge CLK);
      apb(1'b0, 8'h0C, 32'h0);
      compare("halt status", {26'h0, rd[11:8], rd[1:0]}, k[0] ? 32'h22 : 32'h1D);
      IRQ_N <= 1'b0;
      for (int i = 0; i < 20 && CPU_CLK_RUN !== 1'b1; i++) @(negedge CLK);
      @(posedge CLK);
      IRQ_N <= 1'b1;
      compare("woken", {31'h0, OSC_RUN & CPU_CLK_RUN}, 32'h1);
    end
    repeat (100) @(posedge CLK);
    halt;
    compare("indexed core", rd, 32'h0003_1013);
    compare("shift write", {24'h0, mem_i.mem[16'h0080]}, 32'h00);
    check_pc(16'h010B);
    apb(1'b0, 8'h0C, 32'h0);
    compare("status", rd, 32'h0000_005C);
    apb(1'b1, 8'h0C, 32'h0000_0004);
    apb(1'b0, 8'h0C, 32'h0);
    compare("illegal cleared", rd, 32'h0000_0058);
    give_verdict;
  end
endmodule
